// *** hdl/ssr_unit.v ***
// Stack save and restore execution unit
`include "ssr_consts.vh"
module ssr_unit (
    input  wire        CLK_I,
    input  wire        NRST_I,
    input  wire        START_I,
    input  wire [2:0]  OP_I,
    input  wire        BYTE_I,
    input  wire        SHORT_I,
    input  wire [2:0]  SRC_CODE_I,
    input  wire        SRC_IS_MEM_I,
    input  wire [15:0] SRC_VAL_I,
    input  wire [15:0] EA_I,
    input  wire [7:0]  REG_MASK_I,
    input  wire [2:0]  CR_SEL_I,
    input  wire [127:0] REGS_I,
    input  wire [15:0] CR_FB_I,
    input  wire [15:0] CR_SB_I,
    input  wire [15:0] CR_VTH_I,
    input  wire [15:0] CR_VTL_I,
    input  wire [15:0] MEM_RDATA_I,
    output wire        BUSY_O,
    output reg         DONE_O,
    output reg         ILLEGAL_O,
    output reg         MEM_WE_O,
    output reg         MEM_RE_O,
    output reg         MEM_BYTE_O,
    output reg  [15:0] MEM_ADDR_O,
    output reg  [15:0] MEM_WDATA_O,
    output reg         REG_WE_O,
    output reg  [2:0]  REG_IDX_O,
    output reg  [15:0] REG_WDATA_O,
    output reg         PC_WE_O,
    output reg  [19:0] PC_O,
    output reg  [15:0] USP_O,
    output reg  [15:0] ISP_O,
    output reg  [15:0] FLG_O
);
// ============================================================
// States
// One-hot, so a stray code falls back to idle
localparam S_IDLE = 4'h1;
localparam S_MULT = 4'h2;
localparam S_RET1 = 4'h4;
localparam S_RET2 = 4'h8;

reg [3:0]  state_q;
reg [2:0]  op_q;
reg [7:0]  mask_q;
reg [15:0] pc_lo_q;
reg [15:0] sp_now;
reg [2:0]  idx;
reg        found;
reg [15:0] cr_val;
reg        short_ok;
integer    k;
wire [15:0] push_step = BYTE_I ? `SSR_STEP_BYTE : `SSR_STEP_WORD;

// ============================================================
// Stack pointer selection
// Every stack access uses the pointer the select flag names
// stack select choice
always @* begin
    sp_now = FLG_O[`SSR_FLG_U] ? USP_O : ISP_O;
end

// Byte pushes move the pointer by one, all others by two
wire [15:0] sp_dec2 = sp_now - `SSR_STEP_WORD;
wire [15:0] sp_inc2 = sp_now + `SSR_STEP_WORD;
wire [15:0] sp_push = sp_now - push_step;

// ============================================================
// List walker
// Lowest set bit wins for restore, highest for save
// next list entry
always @* begin
    idx   = 3'h0;
    found = 1'b0;
    if (op_q == `SSR_OP_RESTM) begin
        for (k = 7; k >= 0; k = k - 1) begin
            if (mask_q[k]) begin
                idx   = k[2:0];
                found = 1'b1;
            end
        end
    end else begin
        for (k = 0; k < 8; k = k + 1) begin
            if (mask_q[k]) begin
                idx   = k[2:0];
                found = 1'b1;
            end
        end
    end
end

// ============================================================
// Operand helpers
// short form sources
always @* begin
    case (SRC_CODE_I)
    `SSR_SRC_R0L: short_ok = 1'b1;
    `SSR_SRC_R0H: short_ok = 1'b1;
    `SSR_SRC_A0:  short_ok = 1'b1;
    `SSR_SRC_A1:  short_ok = 1'b1;
    default:      short_ok = 1'b0;
    endcase
end

always @* begin
    case (CR_SEL_I)
    `SSR_CR_FB:  cr_val = CR_FB_I;
    `SSR_CR_SB:  cr_val = CR_SB_I;
    // Stack pointer goes out as it stood before the push
    `SSR_CR_SP:  cr_val = sp_now;
    `SSR_CR_ISP: cr_val = ISP_O;
    `SSR_CR_FLG: cr_val = FLG_O;
    `SSR_CR_VTH: cr_val = CR_VTH_I;
    default:     cr_val = CR_VTL_I;
    endcase
end

assign BUSY_O = (state_q != S_IDLE);

// ============================================================
// Sequencer
always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
        state_q     <= S_IDLE;
        op_q        <= 3'h0;
        mask_q      <= 8'h00;
        pc_lo_q     <= 16'h0000;
        DONE_O      <= 1'b0;
        ILLEGAL_O   <= 1'b0;
        MEM_WE_O    <= 1'b0;
        MEM_RE_O    <= 1'b0;
        MEM_BYTE_O  <= 1'b0;
        MEM_ADDR_O  <= 16'h0000;
        MEM_WDATA_O <= 16'h0000;
        REG_WE_O    <= 1'b0;
        REG_IDX_O   <= 3'h0;
        REG_WDATA_O <= 16'h0000;
        PC_WE_O     <= 1'b0;
        PC_O        <= 20'h00000;
        USP_O       <= `SSR_RST_SP;
        ISP_O       <= `SSR_RST_SP;
        FLG_O       <= `SSR_RST_FLG;
    end else begin
        // Strobes last one cycle unless a state raises them
        DONE_O    <= 1'b0;
        ILLEGAL_O <= 1'b0;
        MEM_WE_O  <= 1'b0;
        MEM_RE_O  <= 1'b0;
        REG_WE_O  <= 1'b0;
        PC_WE_O   <= 1'b0;
        case (state_q)
        S_IDLE: begin
            if (START_I) begin
                op_q   <= OP_I;
                mask_q <= REG_MASK_I;
                case (OP_I)
                `SSR_OP_RESTM: begin
                    // First word must already be addressed on the first list cycle
                    MEM_ADDR_O <= sp_now;
                    state_q    <= S_MULT;
                end

                `SSR_OP_SAVEM: begin
                    state_q <= S_MULT;
                end

                `SSR_OP_PUSH: begin
                    if (SHORT_I && !short_ok) begin
                        ILLEGAL_O <= 1'b1;
                    end else begin
                        MEM_WE_O    <= 1'b1;
                        MEM_BYTE_O  <= BYTE_I;
                        MEM_ADDR_O  <= sp_push;
                        MEM_WDATA_O <= BYTE_I ? {8'h00, SRC_VAL_I[7:0]} : SRC_VAL_I;
                        if (FLG_O[`SSR_FLG_U]) begin
                            USP_O <= sp_push;
                        end else begin
                            ISP_O <= sp_push;
                        end
                    end
                    DONE_O <= 1'b1;
                end

                `SSR_OP_PUSHEA: begin
                    if (!SRC_IS_MEM_I) begin
                        ILLEGAL_O <= 1'b1;
                    end else begin
                        MEM_WE_O    <= 1'b1;
                        MEM_BYTE_O  <= 1'b0;
                        MEM_ADDR_O  <= sp_dec2;
                        MEM_WDATA_O <= EA_I;
                        if (FLG_O[`SSR_FLG_U]) begin
                            USP_O <= sp_dec2;
                        end else begin
                            ISP_O <= sp_dec2;
                        end
                    end
                    DONE_O <= 1'b1;
                end

                `SSR_OP_PUSHCR: begin
                    MEM_WE_O    <= 1'b1;
                    MEM_BYTE_O  <= 1'b0;
                    MEM_ADDR_O  <= sp_dec2;
                    MEM_WDATA_O <= cr_val;
                    if (FLG_O[`SSR_FLG_U]) begin
                        USP_O <= sp_dec2;
                    end else begin
                        ISP_O <= sp_dec2;
                    end
                    DONE_O <= 1'b1;
                end

                `SSR_OP_RETI: begin
                    MEM_RE_O   <= 1'b1;
                    MEM_BYTE_O <= 1'b0;
                    MEM_ADDR_O <= sp_now;
                    state_q    <= S_RET1;
                end
                default: begin
                    ILLEGAL_O <= 1'b1;
                    DONE_O    <= 1'b1;
                end
                endcase
            end
        end

        S_MULT: begin
            // Empty list ends the walk
            if (!found) begin
                state_q <= S_IDLE;
                DONE_O  <= 1'b1;
            end else begin
                mask_q[idx] <= 1'b0;
                MEM_BYTE_O  <= 1'b0;
                if (op_q == `SSR_OP_RESTM) begin
                    MEM_RE_O   <= 1'b1;
                    // Address the next word so its data is ready next cycle
                    MEM_ADDR_O <= sp_inc2;
                    REG_WE_O   <= 1'b1;
                    REG_IDX_O  <= idx;
                    REG_WDATA_O <= MEM_RDATA_I;
                    if (FLG_O[`SSR_FLG_U])
                        USP_O <= sp_now + `SSR_STEP_WORD;
                    else
                        ISP_O <= sp_now + `SSR_STEP_WORD;
                end else begin
                    MEM_WE_O    <= 1'b1;
                    MEM_ADDR_O  <= sp_now - `SSR_STEP_WORD;
                    MEM_WDATA_O <= REGS_I[idx*16 +: 16];
                    if (FLG_O[`SSR_FLG_U])
                        USP_O <= sp_now - `SSR_STEP_WORD;
                    else
                        ISP_O <= sp_now - `SSR_STEP_WORD;
                end
            end
        end

        // Return: two stack words, pointer bumped after each
        S_RET1: begin
            pc_lo_q    <= MEM_RDATA_I;
            MEM_RE_O   <= 1'b1;
            MEM_ADDR_O <= sp_now + `SSR_STEP_WORD;
            if (FLG_O[`SSR_FLG_U])
                USP_O <= sp_now + `SSR_STEP_WORD;
            else
                ISP_O <= sp_now + `SSR_STEP_WORD;
            state_q <= S_RET2;
        end

        // Pointer bump uses the old select flag, as the frame was pushed
        S_RET2: begin
            PC_WE_O <= 1'b1;
            PC_O    <= {MEM_RDATA_I[3:0], pc_lo_q};
            FLG_O   <= {MEM_RDATA_I[15:12], 4'h0, MEM_RDATA_I[11:4]};
            if (FLG_O[`SSR_FLG_U])
                USP_O <= sp_now + `SSR_STEP_WORD;
            else
                ISP_O <= sp_now + `SSR_STEP_WORD;
            state_q <= S_IDLE;
            DONE_O  <= 1'b1;
        end

        default: state_q <= S_IDLE;
        endcase
    end
end
endmodule // ssr_unit

// *** include/ssr_consts.vh ***
// Constants for the stack save and restore execution unit
//
// Functional notes
// - Restore multiple loads all selected registers
// - Restore multiple raises pointer two per register
// - Restore order data 0..3, address 0..1, bases
// - Push byte minus one, word minus two first
// - Short push only for four listed sources
// - Effective address push writes address, minus two
// - Control push writes selected control register
// - Stack pointer pushes save pre-decrement value
// - Stack pointer source follows stack select flag
// - Save multiple stores list, pointer minus two each
// - Save order frame base first, data 0 last
// - Return loads pc then pc high and flags
// - Return restores flag bits 15..12 and 7..0 from stack, clears bits 11..8
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
// ============================================================
// Operation codes
`define SSR_OP_RESTM   3'h0
`define SSR_OP_PUSH    3'h1
`define SSR_OP_PUSHEA  3'h2
`define SSR_OP_PUSHCR  3'h3
`define SSR_OP_SAVEM   3'h4
`define SSR_OP_RETI    3'h5
// ============================================================
// Control register selectors
`define SSR_CR_FB      3'h0
`define SSR_CR_SB      3'h1
`define SSR_CR_SP      3'h2
`define SSR_CR_ISP     3'h3
`define SSR_CR_FLG     3'h4
`define SSR_CR_VTH     3'h5
`define SSR_CR_VTL     3'h6
// ============================================================
// Push short-form source codes
`define SSR_SRC_R0L    3'h0
`define SSR_SRC_R0H    3'h1
`define SSR_SRC_A0     3'h2
`define SSR_SRC_A1     3'h3
// ============================================================
// Flag bit position and step sizes
`define SSR_FLG_U      7
`define SSR_STEP_BYTE  16'h0001
`define SSR_STEP_WORD  16'h0002
`define SSR_RST_SP     16'h0000
`define SSR_RST_FLG    16'h0000
`endif

// *** test/ssr_mem.sv ***
// Behavioural memory holding the stack area
module ssr_mem (
    input  logic        clk_i,
    input  logic        we_i,
    input  logic        byte_i,
    input  logic [15:0] addr_i,
    input  logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [0:65535];
    wire  [15:0] nxt = addr_i + 16'h0001;
    // Read is combinational: the unit takes it in the cycle it addresses
    assign rdata_o = {mem[nxt], mem[addr_i]};
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i[7:0];
            if (!byte_i) mem[nxt] <= wdata_i[15:8];
        end
    end
endmodule // ssr_mem

// *** test/ssr_unit_properties.sv ***
// Port checker for the stack save and restore unit
`include "ssr_consts.vh"
module ssr_unit_properties (
    input logic        CLK_I, NRST_I, START_I, BUSY_O, BYTE_I, SHORT_I, SRC_IS_MEM_I,
    input logic        DONE_O, ILLEGAL_O, MEM_WE_O, MEM_BYTE_O, REG_WE_O, PC_WE_O,
    input logic [2:0]  OP_I, SRC_CODE_I, CR_SEL_I, REG_IDX_O,
    input logic [15:0] EA_I, MEM_ADDR_O, MEM_WDATA_O, USP_O, ISP_O, FLG_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // ========
    // Helpers
    wire [15:0] sp = FLG_O[`SSR_FLG_U] ? USP_O : ISP_O;
    wire        go = START_I && !BUSY_O;
    // Last accepted op: flags may only move under a return
    reg  [2:0]  op_q;
    always @(posedge CLK_I or negedge NRST_I)
        if (!NRST_I) op_q <= 3'h0;
        else if (go) op_q <= OP_I;
    // ========
    // Assertions
    a_word_push: assert property (go && OP_I == `SSR_OP_PUSH && !BYTE_I && !SHORT_I
        |=> DONE_O && MEM_WE_O && MEM_ADDR_O == $past(sp) - 16'h0002) else $error("word push wrong");
    a_short_refuse: assert property (go && OP_I == `SSR_OP_PUSH && SHORT_I && SRC_CODE_I > `SSR_SRC_A1
        |=> ILLEGAL_O && !MEM_WE_O && $stable(sp)) else $error("short push not refused");
    a_ea_value: assert property (go && OP_I == `SSR_OP_PUSHEA && SRC_IS_MEM_I
        |=> MEM_WE_O && MEM_WDATA_O == $past(EA_I) && MEM_ADDR_O == $past(sp) - 16'h0002) else $error("ea push wrong");
    a_ea_reject: assert property (go && OP_I == `SSR_OP_PUSHEA && !SRC_IS_MEM_I
        |=> ILLEGAL_O && !MEM_WE_O) else $error("register ea accepted");
    a_sp_presave: assert property (go && OP_I == `SSR_OP_PUSHCR && CR_SEL_I == `SSR_CR_SP
        |=> MEM_WDATA_O == $past(sp)) else $error("sp saved after decrement");
    a_reti_timing: assert property (go && OP_I == `SSR_OP_RETI
        |=> !DONE_O [*2] ##1 (DONE_O && PC_WE_O)) else $error("return timing wrong");
    a_flags_kept: assert property (op_q != `SSR_OP_RETI |-> $stable(FLG_O)) else $error("flags moved");
    a_save_order: assert property (op_q == `SSR_OP_SAVEM && MEM_WE_O && $past(MEM_WE_O)
        |-> MEM_ADDR_O == $past(MEM_ADDR_O) - 16'h0002) else $error("save order wrong");
    a_restore_order: assert property (REG_WE_O && $past(REG_WE_O)
        |-> REG_IDX_O > $past(REG_IDX_O)) else $error("restore order wrong");
    c_refused: cover property (ILLEGAL_O);
    c_savem: cover property (go && OP_I == `SSR_OP_SAVEM);
    c_reti: cover property (go && OP_I == `SSR_OP_RETI);
endmodule // ssr_unit_properties

// *** test/ssr_unit_test.sv ***
// Self-checking bench for the stack save and restore unit
`include "ssr_consts.vh"
module ssr_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic         CLK_I, NRST_I, START_I, BYTE_I, SHORT_I, SRC_IS_MEM_I, ill;
    logic [2:0]   OP_I, SRC_CODE_I, CR_SEL_I;
    logic [7:0]   REG_MASK_I;
    logic [15:0]  SRC_VAL_I, EA_I, CR_FB_I, CR_SB_I, CR_VTH_I, CR_VTL_I, sp, got [0:7];
    logic [127:0] REGS_I;
    wire          BUSY_O, DONE_O, ILLEGAL_O, MEM_WE_O, MEM_RE_O, MEM_BYTE_O, REG_WE_O, PC_WE_O;
    wire  [2:0]   REG_IDX_O;
    wire  [15:0]  MEM_RDATA_I, MEM_ADDR_O, MEM_WDATA_O, REG_WDATA_O, USP_O, ISP_O, FLG_O;
    wire  [19:0]  PC_O;
    int           mismatches, n_tests;
    ssr_unit ssr_unit_inst (
        .CLK_I(CLK_I), .NRST_I(NRST_I), .START_I(START_I), .OP_I(OP_I), .BYTE_I(BYTE_I),
        .SHORT_I(SHORT_I), .SRC_CODE_I(SRC_CODE_I), .SRC_IS_MEM_I(SRC_IS_MEM_I),
        .SRC_VAL_I(SRC_VAL_I), .EA_I(EA_I), .REG_MASK_I(REG_MASK_I), .CR_SEL_I(CR_SEL_I),
        .REGS_I(REGS_I), .CR_FB_I(CR_FB_I), .CR_SB_I(CR_SB_I), .CR_VTH_I(CR_VTH_I),
        .CR_VTL_I(CR_VTL_I), .MEM_RDATA_I(MEM_RDATA_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
        .ILLEGAL_O(ILLEGAL_O), .MEM_WE_O(MEM_WE_O), .MEM_RE_O(MEM_RE_O), .MEM_BYTE_O(MEM_BYTE_O),
        .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .REG_WE_O(REG_WE_O),
        .REG_IDX_O(REG_IDX_O), .REG_WDATA_O(REG_WDATA_O), .PC_WE_O(PC_WE_O), .PC_O(PC_O),
        .USP_O(USP_O), .ISP_O(ISP_O), .FLG_O(FLG_O));
    ssr_mem ssr_mem_inst (.clk_i(CLK_I), .we_i(MEM_WE_O), .byte_i(MEM_BYTE_O), .addr_i(MEM_ADDR_O),
        .wdata_i(MEM_WDATA_O), .rdata_o(MEM_RDATA_I));
    always @(posedge CLK_I)
        if (REG_WE_O === 1'b1) got[REG_IDX_O] <= REG_WDATA_O;
    // ========
    // Shared tasks
    function automatic logic [15:0] rd(input logic [15:0] a);
        return {ssr_mem_inst.mem[a + 16'h0001], ssr_mem_inst.mem[a]};
    endfunction
    task automatic chk(input logic [63:0] e, input logic [63:0] a, input string s);
        n_tests++;
        if (a !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", s, e, a);
        end
    endtask
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded wait so a silent unit cannot hang the run
    task automatic run(input logic [2:0] op);
        int k;
        OP_I <= op;
        START_I <= 1'b1;
        @(posedge CLK_I);
        START_I <= 1'b0;
        // DONE stands one cycle from the edge that raises it: look just after each edge
        for (k = 0; k < 20; k++) begin
            #1;
            if (DONE_O === 1'b1) break;
            @(posedge CLK_I);
        end
        ill = ILLEGAL_O;
        if (k == 20) begin
            mismatches++;
            stop_test;
        end
        @(posedge CLK_I);
        #1;
    endtask
    // ========
    // Scenarios
    task automatic t_push;
        SRC_VAL_I <= 16'h1234;
        run(`SSR_OP_PUSH);
        sp = sp - 16'h0002;
        chk({sp, 16'h1234}, {ISP_O, rd(sp)}, "word push");
        BYTE_I <= 1'b1;
        run(`SSR_OP_PUSH);
        sp = sp - 16'h0001;
        chk({sp, 8'h34}, {ISP_O, ssr_mem_inst.mem[sp]}, "byte push");
        SHORT_I <= 1'b1;
        SRC_CODE_I <= 3'h4;
        run(`SSR_OP_PUSH);
        chk({1'b1, sp}, {ill, ISP_O}, "short refused");
        SRC_CODE_I <= `SSR_SRC_A1;
        BYTE_I <= 1'b0;
        run(`SSR_OP_PUSH);
        sp = sp - 16'h0002;
        chk({1'b0, sp}, {ill, ISP_O}, "short accepted");
        SHORT_I <= 1'b0;
        SRC_IS_MEM_I <= 1'b0;
        EA_I <= 16'hBEEF;
        run(`SSR_OP_PUSHEA);
        chk({1'b1, sp}, {ill, ISP_O}, "register ea");
        SRC_IS_MEM_I <= 1'b1;
        run(`SSR_OP_PUSHEA);
        sp = sp - 16'h0002;
        chk({sp, 16'hBEEF}, {ISP_O, rd(sp)}, "ea push");
        $display("push tests done");
    endtask
    task automatic t_ctrl;
        logic [15:0] e;
        for (int s = 0; s < 7; s++) begin
            CR_SEL_I <= s[2:0];
            run(`SSR_OP_PUSHCR);
            e = s == 0 ? CR_FB_I : s == 1 ? CR_SB_I : s < 4 ? sp : s == 4 ? FLG_O : s == 5 ? CR_VTH_I : CR_VTL_I;
            sp = sp - 16'h0002;
            chk({sp, e}, {ISP_O, rd(sp)}, "control push");
        end
        $display("control tests done");
    endtask
    task automatic t_multi;
        logic [15:0] a;
        REG_MASK_I <= 8'hD3;
        run(`SSR_OP_SAVEM);
        sp = sp - 16'h000A;
        a = sp;
        chk(sp, ISP_O, "save sp");
        for (int i = 0; i < 8; i++) if (REG_MASK_I[i]) begin
            chk(REGS_I[16*i +: 16], rd(a), "save image");
            a = a + 16'h0002;
        end
        run(`SSR_OP_RESTM);
        sp = sp + 16'h000A;
        chk(sp, ISP_O, "restore sp");
        for (int i = 0; i < 8; i++) if (REG_MASK_I[i])
            chk(REGS_I[16*i +: 16], got[i], "restore value");
        $display("multiple tests done");
    endtask
    task automatic t_reti;
        ssr_mem_inst.mem[sp] = 8'h78;
        ssr_mem_inst.mem[sp + 16'h0001] = 8'h56;
        ssr_mem_inst.mem[sp + 16'h0002] = 8'h9A;
        ssr_mem_inst.mem[sp + 16'h0003] = 8'h38;
        run(`SSR_OP_RETI);
        sp = sp + 16'h0004;
        chk(20'hA5678, PC_O, "return pc");
        chk({sp, 8'h89}, {ISP_O, FLG_O[7:0]}, "return sp flags");
        CR_SEL_I <= `SSR_CR_SP;
        run(`SSR_OP_PUSHCR);
        chk({sp, 16'hFFFE, 16'h0000}, {ISP_O, USP_O, rd(16'hFFFE)}, "user sp push");
        $display("return tests done");
    endtask
    initial begin
        CLK_I = 1'b0;
        forever #50 CLK_I = ~CLK_I;
    end
    initial begin
        {NRST_I, START_I, BYTE_I, SHORT_I, SRC_IS_MEM_I, OP_I, SRC_CODE_I, CR_SEL_I, REG_MASK_I} = 22'h0;
        {SRC_VAL_I, EA_I, CR_VTH_I, CR_VTL_I} = 64'h0000_0000_000C_C0DE;
        CR_SB_I = 16'h7777;
        CR_FB_I = 16'h8888;
        for (int i = 0; i < 8; i++) REGS_I[16*i +: 16] = 16'h1111 * (i + 1);
        sp = 16'h0000;
        repeat (20) @(posedge CLK_I);
        NRST_I <= 1'b1;
        t_push;
        t_ctrl;
        t_multi;
        t_reti;
        stop_test;
    end
endmodule // ssr_unit_test
bind ssr_unit ssr_unit_properties ssr_unit_properties_inst (.*);
